// ### pkg/timer_map.vh
// Register map, field positions and timing constants of the trigger timer
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// ----------------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------------
`define ADDR_CTRL 3'h0
`define ADDR_COMPARE 3'h1
`define ADDR_CAPTURE 3'h2
`define ADDR_COUNT 3'h3
`define ADDR_STATUS 3'h4

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_CK_LSB 0
`define CTRL_CK_MSB 1
`define CTRL_MODE_LSB 2
`define CTRL_MODE_MSB 3
`define CTRL_START_LSB 4
`define CTRL_START_MSB 5
`define CTRL_OPT_BIT 6
`define CTRL_USED_MSB 6

// ----------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------
`define MODE_TRIGGER 2'h0
`define MODE_EVENT 2'h1
`define MODE_WINDOW 2'h2
`define MODE_PULSE 2'h3
`define START_STOP 2'h0
`define START_RISE 2'h1
`define START_FALL 2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTRL_RST 7'h00
`define COMPARE_RST 16'hffff
`define CAPTURE_RST 16'h0000
`define COUNT_RST 16'h0000

// ----------------------------------------------------------------------
// Timing, in periods of the high-frequency clock
// ----------------------------------------------------------------------
`define FILT_REJECT_FC 7
`define FILT_ACCEPT_FC 13
`define FILT_CYCLES (`FILT_REJECT_FC + 1)
`define SRC_LOG2_0 7
`define SRC_LOG2_1 3
`define SRC_LOG2_2 1
`define SRC_LOG2_3 0

`endif

// ### hdl/timer_trigger_window_capture.v
// Sixteen-bit trigger, event, window and pulse-width timer with compare
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.vh"

// How it works
// - Trigger mode waits for the start edge, then counts source ticks.
// - Start field picks rising or falling edge as the trigger.
// - Trigger mode match raises interrupt, clears counter and halts it.
// - With reverse-stop set, the opposite edge clears and stops counting.
// - Without reverse-stop, opposite edges and repeated edges are ignored.
// - Pin filter drops pulses of 7 clocks or less, keeps 13 or more.
// - Event mode counts selected pin edges; match interrupts and clears.
// - Event mode checks the match only on the opposite pin edge.
// - Event mode auto-capture copies the running count to capture reg.
// - Window mode counts source ticks while pin gate is active.
// - Window gate polarity follows the start field.
// - Pulse mode starts on trigger, captures and interrupts on opposite.
// - Option bit picks single capture with reload to one, or double capture.
// - Single capture leaves the counter resting at one until next edge.
module timer_trigger_window_capture #(
    parameter CNT_W = 16,
    parameter FILT_W = 4,
    parameter PRESC_W = 8
) (
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire [2:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    input wire timer_pin,
    output reg timer_match_irq
);

    // ------------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;
    // Threshold worked out at full width, then cut to the counter's width
    localparam [31:0] FILT_LAST_FULL = `FILT_CYCLES - 1;
    localparam [FILT_W-1:0] FILT_LAST = FILT_LAST_FULL[FILT_W-1:0];

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Picks the active edge for a rising or falling selection
    function pick_edge;
        input [1:0] start_sel;
        input rise;
        input fall;
        begin
            case (start_sel)
                `START_RISE: pick_edge = rise;
                `START_FALL: pick_edge = fall;
                default: pick_edge = 1'b0;
            endcase
        end
    endfunction

    // All-ones mask of the low bits that must wrap for one source tick
    function [PRESC_W-1:0] tick_mask;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: tick_mask = {PRESC_W{1'b1}} >> (PRESC_W - `SRC_LOG2_0);
                2'h1: tick_mask = {PRESC_W{1'b1}} >> (PRESC_W - `SRC_LOG2_1);
                2'h2: tick_mask = {PRESC_W{1'b1}} >> (PRESC_W - `SRC_LOG2_2);
                default: tick_mask = {PRESC_W{1'b0}};
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    reg [`CTRL_USED_MSB:0] timer_control_reg;
    reg [CNT_W-1:0] compare_value_reg;
    reg [CNT_W-1:0] capture_value_reg;
    reg [CNT_W-1:0] count_reg;
    reg [1:0] state_reg;
    reg [PRESC_W-1:0] presc_reg;
    reg pin_meta_reg;
    reg pin_sync_reg;
    reg [FILT_W-1:0] filt_cnt_reg;
    reg filt_level_reg;
    reg filt_prev_reg;

    wire [1:0] ck_sel;
    wire [1:0] mode_sel;
    wire [1:0] start_control_field;
    wire opt_bit;
    wire pin_rise;
    wire pin_fall;
    wire edge_start;
    wire edge_stop;
    wire src_tick;
    wire gate_open;
    wire match;
    wire [CNT_W-1:0] count_inc;

    assign ck_sel = timer_control_reg[`CTRL_CK_MSB:`CTRL_CK_LSB];
    assign mode_sel = timer_control_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    assign start_control_field =
        timer_control_reg[`CTRL_START_MSB:`CTRL_START_LSB];
    // Bit 6 means reverse-stop, double capture or auto-capture by mode
    assign opt_bit = timer_control_reg[`CTRL_OPT_BIT];
    assign count_inc = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    assign match = (count_reg == compare_value_reg);

    // ------------------------------------------------------------------
    // Pin synchroniser, noise filter and edge detect
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else if (clk_en) begin
            pin_meta_reg <= timer_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // A level change is accepted only after it has held for eight clocks,
    // so seven-clock glitches die while thirteen-clock pulses always pass
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_cnt_reg <= {FILT_W{1'b0}};
            filt_level_reg <= 1'b0;
            filt_prev_reg <= 1'b0;
        end else if (clk_en) begin
            filt_prev_reg <= filt_level_reg;
            if (pin_sync_reg == filt_level_reg) begin
                filt_cnt_reg <= {FILT_W{1'b0}};
            end else if (filt_cnt_reg == FILT_LAST) begin
                filt_cnt_reg <= {FILT_W{1'b0}};
                filt_level_reg <= pin_sync_reg;
            end else begin
                filt_cnt_reg <= filt_cnt_reg + {{(FILT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign pin_rise = filt_level_reg & ~filt_prev_reg;
    assign pin_fall = ~filt_level_reg & filt_prev_reg;
    assign edge_start =
        pick_edge(start_control_field, pin_rise, pin_fall);
    assign edge_stop = pick_edge(start_control_field, pin_fall, pin_rise);
    // Rising selection means active-high window, falling means active-low
    assign gate_open =
        (start_control_field == `START_RISE) ? filt_level_reg :
        ~filt_level_reg;

    // ------------------------------------------------------------------
    // Internal source clock prescaler
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= {PRESC_W{1'b0}};
        end else if (clk_en) begin
            presc_reg <= presc_reg + {{(PRESC_W-1){1'b0}}, 1'b1};
        end
    end

    assign src_tick =
        ((presc_reg & tick_mask(ck_sel)) == tick_mask(ck_sel));

    // ------------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_control_reg <= `CTRL_RST;
            compare_value_reg <= `COMPARE_RST;
        end else if (clk_en && wr) begin
            case (addr)
                `ADDR_CTRL: begin
                    timer_control_reg <= wdata[`CTRL_USED_MSB:0];
                end
                `ADDR_COMPARE: begin
                    compare_value_reg <= wdata[CNT_W-1:0];
                end
                default: begin
                    timer_control_reg <= timer_control_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Counter, state, capture and interrupt
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= `COUNT_RST;
            capture_value_reg <= `CAPTURE_RST;
            state_reg <= ST_IDLE;
            timer_match_irq <= 1'b0;
        end else if (clk_en) begin
            timer_match_irq <= 1'b0;
            if (start_control_field != `START_RISE &&
                start_control_field != `START_FALL) begin
                // Stopped: counter cleared so the next start is clean
                count_reg <= {CNT_W{1'b0}};
                state_reg <= ST_IDLE;
            end else begin
                case (mode_sel)
                    `MODE_TRIGGER: begin
                        case (state_reg)
                            ST_IDLE: begin
                                if (edge_start) begin
                                    state_reg <= ST_RUN;
                                end
                            end
                            ST_RUN: begin
                                if (opt_bit && edge_stop) begin
                                    count_reg <= {CNT_W{1'b0}};
                                    state_reg <= ST_IDLE;
                                end else if (match) begin
                                    timer_match_irq <= 1'b1;
                                    count_reg <= {CNT_W{1'b0}};
                                    state_reg <= ST_IDLE;
                                end else if (src_tick) begin
                                    // Stray edges fall through unheeded
                                    count_reg <= count_inc;
                                end
                            end
                            default: begin
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                    `MODE_EVENT: begin
                        state_reg <= ST_RUN;
                        if (edge_start) begin
                            count_reg <= count_inc;
                        end else if (edge_stop && match) begin
                            timer_match_irq <= 1'b1;
                            count_reg <= {CNT_W{1'b0}};
                        end
                    end
                    `MODE_WINDOW: begin
                        state_reg <= ST_RUN;
                        if (match) begin
                            timer_match_irq <= 1'b1;
                            count_reg <= {CNT_W{1'b0}};
                        end else if (src_tick && gate_open) begin
                            count_reg <= count_inc;
                        end
                    end
                    `MODE_PULSE: begin
                        case (state_reg)
                            ST_IDLE: begin
                                if (edge_start) begin
                                    state_reg <= ST_RUN;
                                end
                            end
                            ST_RUN: begin
                                if (edge_stop) begin
                                    capture_value_reg <= count_reg;
                                    timer_match_irq <= 1'b1;
                                    if (!opt_bit) begin
                                        // Rests at one until the next edge
                                        count_reg <= {{(CNT_W-1){1'b0}},
                                            1'b1};
                                        state_reg <= ST_IDLE;
                                    end else if (src_tick) begin
                                        // Double capture must not lose the
                                        // tick that lands on the capture
                                        count_reg <= count_inc;
                                    end
                                end else if (opt_bit && edge_start) begin
                                    capture_value_reg <= count_reg;
                                    timer_match_irq <= 1'b1;
                                    count_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
                                end else if (src_tick) begin
                                    count_reg <= count_inc;
                                end
                            end
                            default: begin
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
                // Auto-capture samples the count on every enabled clock, one cycle behind
                // its increments, so software must allow for a stale low count
                if (opt_bit && (mode_sel == `MODE_EVENT ||
                    mode_sel == `MODE_WINDOW)) begin
                    capture_value_reg <= count_reg;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read port, data valid the cycle after the strobe
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else if (clk_en) begin
            if (rd) begin
                case (addr)
                    `ADDR_CTRL: begin
                        rdata <= {{(15-`CTRL_USED_MSB){1'b0}},
                            timer_control_reg};
                    end
                    `ADDR_COMPARE: begin
                        rdata <= compare_value_reg;
                    end
                    `ADDR_CAPTURE: begin
                        // Whole word in one read keeps both bytes coherent
                        rdata <= capture_value_reg;
                    end
                    `ADDR_COUNT: begin
                        rdata <= count_reg;
                    end
                    `ADDR_STATUS: begin
                        rdata <= {13'h0000, filt_level_reg, state_reg};
                    end
                    default: begin
                        rdata <= 16'h0000;
                    end
                endcase
            end else begin
                rdata <= 16'h0000;
            end
        end
    end

endmodule // timer_trigger_window_capture
`default_nettype wire

// ### testbench/timer_window_checker_assertions.sv
// Port checker for the trigger, window and capture timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.vh"
// --------------------
// Checker
// --------------------
module timer_window_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic timer_pin,
    input wire logic timer_match_irq
);
    logic [6:0] ctrl_q;
    logic [15:0] cmp_q;
    logic [5:0] quiet_q;
    logic pin_d;
    logic stopped;
    logic edge_mode;
    assign stopped = ctrl_q[5:4] == `START_STOP || ctrl_q[5:4] == 2'h3;
    assign edge_mode = ctrl_q[3:2] == `MODE_EVENT ||
        ctrl_q[3:2] == `MODE_PULSE;
    // Shadow of software writes, frozen like the design when clk_en is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `CTRL_RST;
            cmp_q <= `COMPARE_RST;
            quiet_q <= 6'h00;
            pin_d <= 1'b0;
        end else if (clk_en) begin
            if (wr && addr == `ADDR_CTRL) ctrl_q <= wdata[6:0];
            if (wr && addr == `ADDR_COMPARE) cmp_q <= wdata;
            pin_d <= timer_pin;
            if (timer_pin != pin_d) quiet_q <= 6'h00;
            else if (quiet_q != 6'h3f) quiet_q <= quiet_q + 6'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    rdata_idle_a: assert property (
        !rd && clk_en |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    ctrl_read_a: assert property (
        rd && clk_en && addr == `ADDR_CTRL |=> rdata == {9'h000, ctrl_q})
        else $error("control readback wrong");
    cmp_read_a: assert property (
        rd && clk_en && addr == `ADDR_COMPARE |=> rdata == cmp_q)
        else $error("compare readback wrong");
    bad_addr_a: assert property (
        rd && clk_en && addr > `ADDR_STATUS |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    status_bits_a: assert property (
        rd && clk_en && addr == `ADDR_STATUS
        |=> rdata[15:3] == 13'h0000 && $onehot(rdata[1:0]))
        else $error("status layout wrong");
    irq_pulse_a: assert property (
        timer_match_irq |=> !timer_match_irq)
        else $error("interrupt longer than one cycle");
    stop_quiet_a: assert property (
        stopped && $past(stopped) && $past(stopped, 2) |-> !timer_match_irq)
        else $error("interrupt while stopped");
    quiet_pin_a: assert property (
        edge_mode && quiet_q >= 6'd30 |-> !timer_match_irq)
        else $error("interrupt without a pin edge");
    cover property (timer_match_irq);
    cover property (edge_mode && timer_match_irq);
    cover property (rd && addr == `ADDR_CAPTURE);
endmodule // timer_window_checker
bind timer_trigger_window_capture timer_window_checker chk_u (.clk(clk),
    .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_pin(timer_pin),
    .timer_match_irq(timer_match_irq));
`default_nettype wire

// ### testbench/pin_src.sv
// Model of the external pulse source on the timer pin
`timescale 1ns/1ps
`default_nettype none
module pin_src (
    input wire logic clk,
    output var logic timer_pin
);
    initial timer_pin = 1'b0;
    // Push-pull source: the caller picks each width, so slow changes hold
    task automatic drive(input logic lvl, input int n);
        timer_pin <= lvl;
        repeat (n) @(posedge clk);
        #1;
    endtask
endmodule // pin_src
`default_nettype wire

// ### testbench/timer_trigger_window_capture_tb_top.sv
// Self-checking bench for the trigger, window and capture timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.vh"
`define CHECK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
end
module timer_trigger_window_capture_tb_top;
    logic clk, rst_n, clk_en, wr, rd;
    logic [2:0] addr;
    logic [15:0] wdata;
    wire logic [15:0] rdata;
    wire logic timer_pin, timer_match_irq;
    int err_total, samples_checked, k, win_exp;
    logic [15:0] cap [0:2];
    timer_trigger_window_capture dut_u (.clk(clk), .rst_n(rst_n),
        .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer_pin(timer_pin),
        .timer_match_irq(timer_match_irq));
    pin_src pin_u (.clk(clk), .timer_pin(timer_pin));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task wr_reg(input logic [2:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task rd_reg(input logic [2:0] a, output logic [15:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task rd_chk(input logic [2:0] a, input logic [15:0] e, input string nm);
        logic [15:0] got;
        rd_reg(a, got);
        `CHECK(nm, e, got)
    endtask
    task irq_chk(input int lim, input logic e, input string nm);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge clk);
            #1;
            hit = timer_match_irq;
        end
        `CHECK(nm, e, hit)
    endtask
    // Mode bits only change while stopped, with the pin settled at idle
    task set_mode(input logic [15:0] ctl, input logic idle);
        wr_reg(`ADDR_CTRL, 16'h0000);
        pin_u.drive(idle, 16);
        wr_reg(`ADDR_CTRL, ctl);
    endtask
    function logic near(input logic [15:0] x, input int e);
        return x >= e - 1 && x <= e + 1;
    endfunction
    task end_sim;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim;
    end
    initial begin
        err_total = 0;
        samples_checked = 0;
        {rst_n, wr, rd, addr, wdata} = '0;
        clk_en = 1'b1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        rd_chk(`ADDR_CTRL, `CTRL_RST, "ctrl_rst");
        rd_chk(`ADDR_COMPARE, `COMPARE_RST, "cmp_rst");
        wr_reg(`ADDR_CAPTURE, 16'h1234);
        rd_chk(`ADDR_CAPTURE, `CAPTURE_RST, "cap_ro");
        rd_chk(3'h7, 16'h0000, "unmapped");
        rd_chk(`ADDR_STATUS, 16'h0001, "status");
        // --------------------
        // Trigger mode: both start edges, reverse stop off and on
        // --------------------
        wr_reg(`ADDR_COMPARE, 16'h0014);
        for (k = 0; k < 4; k++) begin
            set_mode({9'h000, k[1], k[0] ? `START_FALL : `START_RISE,
                `MODE_TRIGGER, 2'h3}, k[0]);
            rd_chk(`ADDR_COUNT, 16'h0000, "held");
            pin_u.drive(!k[0], 14);
            pin_u.drive(k[0], 1);
            irq_chk(60, !k[1], "trig_irq");
            rd_chk(`ADDR_COUNT, 16'h0000, "halted");
        end
        set_mode(16'h0013, 1'b0);
        pin_u.drive(1'b1, 7);
        pin_u.drive(1'b0, 20);
        irq_chk(50, 1'b0, "glitch");
        pin_u.drive(1'b1, 13);
        pin_u.drive(1'b0, 1);
        irq_chk(60, 1'b1, "pulse13");
        // --------------------
        // Event counter and auto-capture
        // --------------------
        wr_reg(`ADDR_COMPARE, 16'h0003);
        set_mode(16'h0017, 1'b0);
        for (k = 1; k <= 3; k++) begin
            pin_u.drive(1'b1, 10);
            pin_u.drive(1'b0, 1);
            irq_chk(16, k == 3, "evt_irq");
            rd_chk(`ADDR_COUNT, k % 3, "evt_cnt");
        end
        wr_reg(`ADDR_CTRL, 16'h0057);
        pin_u.drive(1'b1, 16);
        rd_chk(`ADDR_CAPTURE, 16'h0001, "auto_cap");
        // --------------------
        // Window mode, both gate polarities, slower ticks, then a match
        // --------------------
        wr_reg(`ADDR_COMPARE, 16'hffff);
        for (k = 0; k < 4; k++) begin
            set_mode({10'h000, k == 1 ? `START_FALL : `START_RISE,
                `MODE_WINDOW, k[1] ? {~k[0], k[0]} : 2'h3}, k == 1);
            pin_u.drive(k != 1, 30);
            pin_u.drive(k == 1, 20);
            rd_reg(`ADDR_COUNT, cap[0]);
            win_exp = k[1] ? (k[0] ? 4 : 15) : 30;
            `CHECK("win_cnt", 1'b1, near(cap[0], win_exp))
        end
        wr_reg(`ADDR_COMPARE, 16'h0014);
        set_mode(16'h001b, 1'b0);
        pin_u.drive(1'b1, 1);
        irq_chk(40, 1'b1, "win_irq");
        wr_reg(`ADDR_CTRL, 16'h003b);
        pin_u.drive(1'b1, 20);
        rd_chk(`ADDR_COUNT, 16'h0000, "stop_code");
        rd_chk(`ADDR_STATUS, 16'h0005, "status_pin");
        // --------------------
        // Pulse width, single then double edge capture
        // --------------------
        wr_reg(`ADDR_COMPARE, 16'hffff);
        set_mode(16'h001f, 1'b0);
        for (k = 0; k < 3; k++) begin
            pin_u.drive(1'b1, 30);
            pin_u.drive(1'b0, 1);
            irq_chk(20, 1'b1, "pw_irq");
            rd_reg(`ADDR_CAPTURE, cap[k]);
            pin_u.drive(1'b0, 10);
        end
        `CHECK("pw_width", 1'b1, near(cap[1], 31))
        `CHECK("pw_rest", cap[0] + 16'h0001, cap[1])
        `CHECK("pw_again", cap[1], cap[2])
        set_mode(16'h005f, 1'b0);
        pin_u.drive(1'b1, 20);
        pin_u.drive(1'b0, 14);
        rd_reg(`ADDR_CAPTURE, cap[0]);
        pin_u.drive(1'b0, 10);
        pin_u.drive(1'b1, 16);
        rd_reg(`ADDR_CAPTURE, cap[1]);
        `CHECK("dbl_first", 1'b1, near(cap[0], 20))
        `CHECK("dbl_span", 16'd25, cap[1] - cap[0])
        // --------------------
        // Clock enable low ignores the bus
        // --------------------
        wr_reg(`ADDR_CTRL, 16'h0000);
        clk_en <= 1'b0;
        wr_reg(`ADDR_CTRL, 16'h0013);
        clk_en <= 1'b1;
        rd_chk(`ADDR_CTRL, 16'h0000, "frozen");
        end_sim;
    end
endmodule // timer_trigger_window_capture_tb_top
`default_nettype wire
